// ### verilog/pfm_pkg.sv
// constants and carrier types for the pin function multiplexer
package pfm_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PA_PINS = 8;
  localparam int unsigned PB_PINS = 6;
  localparam int unsigned ALL_PINS = 14;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_PA_LO_SEL = 12'h000;
  localparam logic [11:0] OFS_PA_HI_SEL = 12'h004;
  localparam logic [11:0] OFS_PB_LO_SEL = 12'h008;
  localparam logic [11:0] OFS_PB_HI_SEL = 12'h00C;
  localparam logic [11:0] OFS_SER_SRC   = 12'h010;
  localparam logic [11:0] OFS_TMR_SRC   = 12'h014;
  localparam logic [11:0] OFS_PA_DATA   = 12'h018;
  localparam logic [11:0] OFS_PA_DIR    = 12'h01C;
  localparam logic [11:0] OFS_PB_DATA   = 12'h020;
  localparam logic [11:0] OFS_PB_DIR    = 12'h024;
  localparam logic [11:0] OFS_PA_LEVEL  = 12'h028;
  localparam logic [11:0] OFS_PB_LEVEL  = 12'h02C;

  // ****************************************
  // implemented bit masks and reset values
  // ****************************************
  localparam logic [7:0] MASK_PA_LO_SEL = 8'hCF;
  localparam logic [7:0] MASK_FULL      = 8'hFF;
  localparam logic [7:0] MASK_PB_HI_SEL = 8'h0F;
  localparam logic [7:0] MASK_TMR_SRC   = 8'h1F;
  localparam logic [7:0] MASK_PORT_B    = 8'h3F;
  localparam logic [7:0] RST_SEL        = 8'h00;
  localparam logic [7:0] RST_PORT       = 8'hFF;
  localparam logic [13:0] RST_LEVEL     = 14'h0000;

  // ****************************************
  // field positions in the input source selectors
  // ****************************************
  localparam int unsigned POS_SDI_SRC  = 6;
  localparam int unsigned POS_SCK_SRC  = 4;
  localparam int unsigned POS_SCS_SRC  = 2;
  localparam int unsigned POS_RX_SRC   = 0;
  localparam int unsigned POS_COMPACT_TIMER_CLOCK_IN_SRC = 3;
  localparam int unsigned POS_TIMER_CAPTURE_IN_SRC = 2;
  localparam int unsigned POS_PERIODIC_TIMER_CLOCK_IN_SRC = 1;
  localparam int unsigned POS_IRQ_SRC  = 0;

  // pin drive pair {output enable, level} for an undriven pin
  localparam logic [1:0] PAIR_OFF = 2'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ctp_out;  // compact timer output
    logic ptp_out;  // periodic timer output
    logic tx_out;   // uart transmit level
    logic tx_oe;    // uart drives a shared rx/tx pin
    logic sdo_out;  // serial data out
    logic sck_out;  // serial clock out
    logic sck_oe;
    logic sda_out;  // serial data in/out (two-wire)
    logic sda_oe;
    logic scs_out;  // serial chip select out
    logic scs_oe;
  } pfm_periph_out_t;

  typedef struct packed {
    logic serial_data_in;
    logic serial_clock_in;
    logic chip_select_in;
    logic uart_receive_in;
    logic compact_timer_clock_in;
    logic timer_capture_in;
    logic periodic_timer_clock_in;
    logic ext_irq_in;
  } pfm_periph_in_t;

  typedef struct packed {
    logic analog_channel_0;
    logic analog_channel_1;
    logic analog_channel_3;
    logic analog_channel_4;
    logic reference_voltage_out;
    logic reference_voltage_in;
  } pfm_analog_t;

endpackage

// ### verilog/pfm_pin_function_mux.sv
// pin function multiplexer: apb registers, pin output muxing, input routing
`timescale 1ns/1ps
`default_nettype none

module pfm_pin_function_mux (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  // port a pins
  input  wire logic [7:0]               pa_pin_in,
  output logic [7:0]                    pa_pin_out,
  output logic [7:0]                    pa_pin_oe,
  // port b pins
  input  wire logic [5:0]               pb_pin_in,
  output logic [5:0]                    pb_pin_out,
  output logic [5:0]                    pb_pin_oe,
  // peripherals
  input  wire pfm_pkg::pfm_periph_out_t periph_out,
  output pfm_pkg::pfm_periph_in_t       periph_in,
  output pfm_pkg::pfm_analog_t          analog_en
);

  // ****************************************
  // selection helpers
  // ****************************************
  function automatic logic [1:0] pick_pair(input logic [1:0] code, input logic [1:0] f0,
                                           input logic [1:0] f1, input logic [1:0] f2,
                                           input logic [1:0] f3);
    pick_pair = code[1] ? (code[0] ? f3 : f2) : (code[0] ? f1 : f0);
  endfunction

  function automatic logic pick_bit(input logic [1:0] code, input logic b0, input logic b1,
                                    input logic b2, input logic b3);
    pick_bit = code[1] ? (code[0] ? b3 : b2) : (code[0] ? b1 : b0);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  pa_lo_sel_q;
  logic [7:0]  pa_hi_sel_q;
  logic [7:0]  pb_lo_sel_q;
  logic [7:0]  pb_hi_sel_q;
  logic [7:0]  ser_src_q;
  logic [7:0]  tmr_src_q;
  logic [7:0]  pa_dat_q;
  logic [7:0]  pa_dir_q;
  logic [7:0]  pb_dat_q;
  logic [7:0]  pb_dir_q;
  logic [31:0] prdata_q;
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;
  logic [13:0] sync3_q;
  logic [13:0] lvl_q;
  logic [13:0] lvl_d;
  logic [7:0]  pa_out_q;
  logic [7:0]  pa_oe_q;
  logic [5:0]  pb_out_q;
  logic [5:0]  pb_oe_q;
  pfm_pkg::pfm_periph_in_t periph_in_q;
  pfm_pkg::pfm_periph_in_t periph_in_d;
  pfm_pkg::pfm_analog_t    analog_q;
  pfm_pkg::pfm_analog_t    analog_d;

  // ****************************************
  // apb decode
  // ****************************************
  logic        acc_phase;
  logic        setup_rd;
  logic        addr_hit;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;

  // zero wait states: the access phase always completes in its first cycle
  assign acc_phase = psel & penable;
  assign setup_rd  = psel & ~penable & ~pwrite;
  assign addr_hit  = (paddr == pfm_pkg::OFS_PA_LO_SEL) | (paddr == pfm_pkg::OFS_PA_HI_SEL) |
                     (paddr == pfm_pkg::OFS_PB_LO_SEL) | (paddr == pfm_pkg::OFS_PB_HI_SEL) |
                     (paddr == pfm_pkg::OFS_SER_SRC)   | (paddr == pfm_pkg::OFS_TMR_SRC)   |
                     (paddr == pfm_pkg::OFS_PA_DATA)   | (paddr == pfm_pkg::OFS_PA_DIR)    |
                     (paddr == pfm_pkg::OFS_PB_DATA)   | (paddr == pfm_pkg::OFS_PB_DIR)    |
                     (paddr == pfm_pkg::OFS_PA_LEVEL)  | (paddr == pfm_pkg::OFS_PB_LEVEL);
  assign wr_en     = acc_phase & pwrite & addr_hit & pstrb[0];
  assign wbyte     = pwdata[7:0];
  assign pready    = acc_phase;
  assign pslverr   = acc_phase & ~addr_hit;
  assign prdata    = prdata_q;

  // read mux; unimplemented bits were never stored and read as zero
  assign rd_byte = (paddr == pfm_pkg::OFS_PA_LO_SEL) ? pa_lo_sel_q :
                   (paddr == pfm_pkg::OFS_PA_HI_SEL) ? pa_hi_sel_q :
                   (paddr == pfm_pkg::OFS_PB_LO_SEL) ? pb_lo_sel_q :
                   (paddr == pfm_pkg::OFS_PB_HI_SEL) ? pb_hi_sel_q :
                   (paddr == pfm_pkg::OFS_SER_SRC)   ? ser_src_q   :
                   (paddr == pfm_pkg::OFS_TMR_SRC)   ? tmr_src_q   :
                   (paddr == pfm_pkg::OFS_PA_DATA)   ? pa_dat_q    :
                   (paddr == pfm_pkg::OFS_PA_DIR)    ? pa_dir_q    :
                   (paddr == pfm_pkg::OFS_PB_DATA)   ? pb_dat_q    :
                   (paddr == pfm_pkg::OFS_PB_DIR)    ? pb_dir_q    :
                   (paddr == pfm_pkg::OFS_PA_LEVEL)  ? lvl_q[7:0]  :
                   (paddr == pfm_pkg::OFS_PB_LEVEL)  ? {2'h0, lvl_q[13:8]} : 8'h00;

  // read data captured in the setup cycle, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

  // ****************************************
  // selection registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_lo_sel_q <= pfm_pkg::RST_SEL;
      pa_hi_sel_q <= pfm_pkg::RST_SEL;
      pb_lo_sel_q <= pfm_pkg::RST_SEL;
      pb_hi_sel_q <= pfm_pkg::RST_SEL;
      ser_src_q   <= pfm_pkg::RST_SEL;
      tmr_src_q   <= pfm_pkg::RST_SEL;
    end else if (wr_en) begin
      if (paddr == pfm_pkg::OFS_PA_LO_SEL) pa_lo_sel_q <= wbyte & pfm_pkg::MASK_PA_LO_SEL;
      if (paddr == pfm_pkg::OFS_PA_HI_SEL) pa_hi_sel_q <= wbyte & pfm_pkg::MASK_FULL;
      if (paddr == pfm_pkg::OFS_PB_LO_SEL) pb_lo_sel_q <= wbyte & pfm_pkg::MASK_FULL;
      if (paddr == pfm_pkg::OFS_PB_HI_SEL) pb_hi_sel_q <= wbyte & pfm_pkg::MASK_PB_HI_SEL;
      if (paddr == pfm_pkg::OFS_SER_SRC)   ser_src_q   <= wbyte & pfm_pkg::MASK_FULL;
      if (paddr == pfm_pkg::OFS_TMR_SRC)   tmr_src_q   <= wbyte & pfm_pkg::MASK_TMR_SRC;
    end
  end

  // ****************************************
  // port data latches and direction bits
  // ****************************************
  // all pins come up as inputs with latches high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_dat_q <= pfm_pkg::RST_PORT;
      pa_dir_q <= pfm_pkg::RST_PORT;
      pb_dat_q <= pfm_pkg::RST_PORT & pfm_pkg::MASK_PORT_B;
      pb_dir_q <= pfm_pkg::RST_PORT & pfm_pkg::MASK_PORT_B;
    end else if (wr_en) begin
      if (paddr == pfm_pkg::OFS_PA_DATA) pa_dat_q <= wbyte;
      if (paddr == pfm_pkg::OFS_PA_DIR)  pa_dir_q <= wbyte;
      if (paddr == pfm_pkg::OFS_PB_DATA) pb_dat_q <= wbyte & pfm_pkg::MASK_PORT_B;
      if (paddr == pfm_pkg::OFS_PB_DIR)  pb_dir_q <= wbyte & pfm_pkg::MASK_PORT_B;
    end
  end

  // ****************************************
  // pin output selection
  // ****************************************
  logic [1:0] pa_gp [0:7];
  logic [1:0] pb_gp [0:5];
  logic [1:0] pa_nx [0:7];
  logic [1:0] pb_nx [0:5];
  logic [1:0] ctp_p;
  logic [1:0] ptp_p;
  logic [1:0] tx_p;
  logic [1:0] rxtx_p;
  logic [1:0] sdo_p;
  logic [1:0] sck_p;
  logic [1:0] sda_p;
  logic [1:0] scs_p;

  // gpio drive pair: enabled while the direction bit says output
  for (genvar i = 0; i < 8; i++) begin : g_pa_gp
    assign pa_gp[i] = {~pa_dir_q[i], pa_dat_q[i]};
  end
  for (genvar j = 0; j < 6; j++) begin : g_pb_gp
    assign pb_gp[j] = {~pb_dir_q[j], pb_dat_q[j]};
  end

  // peripheral drive pairs
  assign ctp_p  = {1'b1, periph_out.ctp_out};
  assign ptp_p  = {1'b1, periph_out.ptp_out};
  assign tx_p   = {1'b1, periph_out.tx_out};
  assign rxtx_p = {periph_out.tx_oe, periph_out.tx_out};
  assign sdo_p  = {1'b1, periph_out.sdo_out};
  assign sck_p  = {periph_out.sck_oe, periph_out.sck_out};
  assign sda_p  = {periph_out.sda_oe, periph_out.sda_out};
  assign scs_p  = {periph_out.scs_oe, periph_out.scs_out};

  // per-pin choice; analog and reference codes leave the digital driver off
  assign pa_nx[0] = pick_pair(pa_lo_sel_q[1:0], pa_gp[0], ptp_p,
                              pfm_pkg::PAIR_OFF, pa_gp[0]);
  assign pa_nx[1] = pick_pair(pa_lo_sel_q[3:2], pa_gp[1], ctp_p, sck_p, pfm_pkg::PAIR_OFF);
  assign pa_nx[2] = pa_gp[2];
  assign pa_nx[3] = pick_pair(pa_lo_sel_q[7:6], pa_gp[3], ctp_p, rxtx_p, scs_p);
  assign pa_nx[4] = pick_pair(pa_hi_sel_q[1:0], pa_gp[4], sdo_p,
                              pfm_pkg::PAIR_OFF, pa_gp[4]);
  assign pa_nx[5] = pick_pair(pa_hi_sel_q[3:2], pa_gp[5], tx_p, sda_p, pfm_pkg::PAIR_OFF);
  assign pa_nx[6] = pick_pair(pa_hi_sel_q[5:4], pa_gp[6], tx_p, scs_p, pfm_pkg::PAIR_OFF);
  assign pa_nx[7] = pick_pair(pa_hi_sel_q[7:6], pa_gp[7], rxtx_p, sdo_p, pfm_pkg::PAIR_OFF);
  assign pb_nx[0] = pick_pair(pb_lo_sel_q[1:0], pb_gp[0], sda_p, pb_gp[0], pb_gp[0]);
  assign pb_nx[1] = pick_pair(pb_lo_sel_q[3:2], pb_gp[1], rxtx_p, sda_p, pb_gp[1]);
  assign pb_nx[2] = pick_pair(pb_lo_sel_q[5:4], pb_gp[2], ptp_p, tx_p, sck_p);
  assign pb_nx[3] = pick_pair(pb_lo_sel_q[7:6], pb_gp[3], ctp_p, tx_p, sdo_p);
  assign pb_nx[4] = pick_pair(pb_hi_sel_q[1:0], pb_gp[4], sck_p, pb_gp[4], pb_gp[4]);
  assign pb_nx[5] = pick_pair(pb_hi_sel_q[3:2], pb_gp[5], rxtx_p, scs_p, pb_gp[5]);

  // output register stage on the pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out_q <= 8'h00;
      pa_oe_q  <= 8'h00;
      pb_out_q <= 6'h00;
      pb_oe_q  <= 6'h00;
    end else begin
      for (int k = 0; k < 8; k++) begin
        pa_oe_q[k]  <= pa_nx[k][1];
        pa_out_q[k] <= pa_nx[k][0];
      end
      for (int m = 0; m < 6; m++) begin
        pb_oe_q[m]  <= pb_nx[m][1];
        pb_out_q[m] <= pb_nx[m][0];
      end
    end
  end

  assign pa_pin_out = pa_out_q;
  assign pa_pin_oe  = pa_oe_q;
  assign pb_pin_out = pb_out_q;
  assign pb_pin_oe  = pb_oe_q;

  // ****************************************
  // pin input synchroniser and filter
  // ****************************************
  // a level is accepted once the second and third stages agree
  assign lvl_d = (sync3_q & ~(sync2_q ^ sync3_q)) | (lvl_q & (sync2_q ^ sync3_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= pfm_pkg::RST_LEVEL;
      sync2_q <= pfm_pkg::RST_LEVEL;
      sync3_q <= pfm_pkg::RST_LEVEL;
      lvl_q   <= pfm_pkg::RST_LEVEL;
    end else begin
      sync1_q <= {pb_pin_in, pa_pin_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q   <= lvl_d;
    end
  end

  // ****************************************
  // peripheral input routing
  // ****************************************
  logic [7:0] pa_lvl;
  logic [5:0] pb_lvl;
  assign pa_lvl = lvl_q[7:0];
  assign pb_lvl = lvl_q[13:8];

  // sources follow the pin level whatever the pin's output selection
  assign periph_in_d.serial_data_in = pick_bit(ser_src_q[7:6],
                                      pa_lvl[5], pb_lvl[0], pb_lvl[1], pa_lvl[5]);
  assign periph_in_d.serial_clock_in = pick_bit(ser_src_q[5:4],
                                       pa_lvl[1], pb_lvl[2], pb_lvl[4], pa_lvl[1]);
  assign periph_in_d.chip_select_in = pick_bit(ser_src_q[3:2],
                                      pa_lvl[6], pa_lvl[3], pb_lvl[5], pa_lvl[6]);
  assign periph_in_d.uart_receive_in = pick_bit(ser_src_q[1:0],
                                       pb_lvl[5], pa_lvl[3], pa_lvl[7], pb_lvl[1]);
  assign periph_in_d.compact_timer_clock_in = pick_bit(tmr_src_q[4:3],
                                              pa_lvl[5], pb_lvl[1], pa_lvl[4], pa_lvl[5]);
  assign periph_in_d.timer_capture_in = tmr_src_q[2] ? pb_lvl[0] : pa_lvl[6];
  assign periph_in_d.periodic_timer_clock_in = tmr_src_q[1] ? pb_lvl[4] : pa_lvl[7];
  assign periph_in_d.ext_irq_in = tmr_src_q[0] ? pb_lvl[5] : pa_lvl[0];

  // analog and reference switches from the output selectors
  assign analog_d.analog_channel_0      = (pa_lo_sel_q[1:0] == 2'h2);
  assign analog_d.analog_channel_1      = (pa_lo_sel_q[3:2] == 2'h3);
  assign analog_d.analog_channel_3      = (pa_hi_sel_q[3:2] == 2'h3);
  assign analog_d.analog_channel_4      = (pa_hi_sel_q[1:0] == 2'h2);
  assign analog_d.reference_voltage_out = (pa_hi_sel_q[7:6] == 2'h3);
  assign analog_d.reference_voltage_in  = (pa_hi_sel_q[5:4] == 2'h3);

  // registered routing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_in_q <= '0;
      analog_q    <= '0;
    end else begin
      periph_in_q <= periph_in_d;
      analog_q    <= analog_d;
    end
  end

  assign periph_in = periph_in_q;
  assign analog_en = analog_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_q <= 1'b0;
    end else if (wr_en) begin
      wr_seen_q <= 1'b1;
    end
  end

  port_reset_a: assert property (!wr_seen_q |-> (pa_dir_q == 8'hFF && pa_dat_q == 8'hFF &&
                  pa_oe_q == 8'h00 && pb_oe_q == 6'h00))
    else $error("pins not inputs with high latches after reset");
  pa3_func_a: assert property ((pa_lo_sel_q[7:6] == 2'h1) |=>
                  (pa_oe_q[3] && pa_out_q[3] == $past(periph_out.ctp_out)))
    else $error("port a pin3 not driven by compact timer");
  pa1_analog_a: assert property ((pa_lo_sel_q[3:2] == 2'h3) |=>
                  (!pa_oe_q[1] && analog_en.analog_channel_1))
    else $error("port a pin1 analog select not honoured");
  pa0_gpio_a: assert property ((pa_lo_sel_q[1:0] == 2'h3) |=>
                  (pa_oe_q[0] == !$past(pa_dir_q[0]) && !analog_en.analog_channel_0))
    else $error("port a pin0 code 11 not gpio");
  pa7_sdo_a: assert property ((pa_hi_sel_q[7:6] == 2'h2) |=>
                  (pa_oe_q[7] && pa_out_q[7] == $past(periph_out.sdo_out)))
    else $error("port a pin7 not driven by serial data out");
  pa6_tx_a: assert property ((pa_hi_sel_q[5:4] == 2'h1) |=>
                  (pa_oe_q[6] && pa_out_q[6] == $past(periph_out.tx_out)))
    else $error("port a pin6 not driven by tx");
  pb0_gpio_a: assert property ((pb_lo_sel_q[1:0] != 2'h1) |=>
                  (pb_oe_q[0] == !$past(pb_dir_q[0]) && pb_out_q[0] == $past(pb_dat_q[0])))
    else $error("port b pin0 not gpio outside code 01");
  pb2_sck_a: assert property ((pb_lo_sel_q[5:4] == 2'h3) |=>
                  (pb_oe_q[2] == $past(periph_out.sck_oe)))
    else $error("port b pin2 not following serial clock enable");
  sdi_route_a: assert property ((ser_src_q[7:6] == 2'h2) |=>
                  (periph_in.serial_data_in == $past(lvl_q[9])))
    else $error("serial data input not from port b pin1");
  rx_route_a: assert property ((ser_src_q[1:0] == 2'h3) |=>
                  (periph_in.uart_receive_in == $past(lvl_q[9])))
    else $error("uart receive not from port b pin1");
  irq_route_a: assert property ((tmr_src_q[0] && pb_hi_sel_q[3:2] == 2'h2) |=>
                  (periph_in.ext_irq_in == $past(lvl_q[13])))
    else $error("interrupt input not from port b pin5");
  lvl_filter_a: assert property ((sync2_q[0] != sync3_q[0]) |=> $stable(lvl_q[0]))
    else $error("pin level changed while stages disagree");

endmodule

`default_nettype wire

// ### bench/pfm_far_side.sv
// far side model: pad wires and peripheral outputs
`timescale 1ns/1ps
`default_nettype none

module pfm_far_side (
  // drive from the design and from outside
  input  wire logic [13:0]         pin_out,
  input  wire logic [13:0]         pin_oe,
  input  wire logic [13:0]         ext_lvl,
  input  wire logic [10:0]         pat,
  // resolved pads and peripheral outputs
  output logic [13:0]              pad,
  output pfm_pkg::pfm_periph_out_t periph_out
);
  // a pad follows the design while enabled, else the outside level
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  // peripheral levels and enables held by the bench pattern
  assign periph_out = pat;
endmodule

`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic                      pready;
  logic                      pslverr;
  logic [11:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic [7:0]                pa_out;
  logic [7:0]                pa_oe;
  logic [5:0]                pb_out;
  logic [5:0]                pb_oe;
  logic [13:0]               pad;
  logic [13:0]               ext_lvl;
  logic [10:0]               pat;
  logic [31:0]               rnd;
  logic [31:0]               e;
  logic [32:0]               exp_q[$];
  pfm_pkg::pfm_periph_out_t  periph_out;
  pfm_pkg::pfm_periph_in_t   periph_in;
  pfm_pkg::pfm_analog_t      analog_en;
  int                        errors = 0;
  int                        samples_checked = 0;
  int                        cyc = 0;
  logic [7:0]  msk[6] = '{8'hCF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h1F};
  logic [31:0] rt[21] = '{32'h10000705, 32'h10C00705, 32'h10400708, 32'h10800709,
    32'h1010060A, 32'h1020060C, 32'h10040503, 32'h1008050D, 32'h10010403, 32'h10020407,
    32'h10030409, 32'h1000040D, 32'h14080309, 32'h14100304, 32'h14180305, 32'h14040208,
    32'h14000206, 32'h1402010C, 32'h14000107, 32'h1401000D, 32'h14000000};

  pfm_pin_function_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .pa_pin_in(pad[7:0]), .pa_pin_out(pa_out),
    .pa_pin_oe(pa_oe), .pb_pin_in(pad[13:8]), .pb_pin_out(pb_out), .pb_pin_oe(pb_oe),
    .periph_out(periph_out), .periph_in(periph_in), .analog_en(analog_en));
  pfm_far_side far (.pin_out({pb_out, pa_out}), .pin_oe({pb_oe, pa_oe}), .ext_lvl(ext_lvl),
    .pat(pat), .pad(pad), .periph_out(periph_out));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    exp_q.push_back({1'b0, 24'h000000, d});
    apb(1'b0, a, 8'h00);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // clock, monitor, timeout
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // read results meet the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_lvl, pat} = '0;
    rnd = 32'h38FE2F4F;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // selector reset values and implemented bits
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i), 8'h00);
      apb(1'b1, 12'(4 * i), 8'hFF);
      rd(12'(4 * i), msk[i]);
      apb(1'b1, 12'(4 * i), 8'h00);
    end
    rd(12'h018, 8'hFF);
    rd(12'h01C, 8'hFF);
    rd(12'h020, 8'h3F);
    rd(12'h024, 8'h3F);
    exp_q.push_back({1'b1, 32'h00000000});
    apb(1'b0, 12'h030, 8'h00);
    $display("test registers done");
    // each source code except serial clock and chip select codes 0 and 3 and compact timer clock code 0 routes its pin to the peripheral input
    for (int i = 0; i < 21; i++) begin
      e = rt[i];
      apb(1'b1, {4'h0, e[31:24]}, e[23:16]);
      rnd = lfsr(rnd);
      ext_lvl <= rnd[13:0];
      repeat (8) @(posedge pclk);
      check("periph_in", periph_in[e[10:8]], pad[e[3:0]]);
    end
    $display("test routing done");
    // output functions drive only while selected
    apb(1'b1, 12'h000, 8'h01);
    rnd = lfsr(rnd);
    pat <= rnd[10:0];
    repeat (3) @(posedge pclk);
    check("ptp pin", {pa_oe[0], pa_out[0]}, {1'b1, periph_out.ptp_out});
    apb(1'b1, 12'h000, 8'h02);
    repeat (3) @(posedge pclk);
    check("an0 pin", {pa_oe[0], analog_en.analog_channel_0}, 33'h1);
    apb(1'b1, 12'h008, 8'hC0);
    repeat (3) @(posedge pclk);
    check("sdo pin", {pb_oe[3], pb_out[3]}, {1'b1, periph_out.sdo_out});
    // timer, serial and uart functions on port a, chip select and irq on port b pin5
    apb(1'b1, 12'h000, 8'h40);
    apb(1'b1, 12'h004, 8'h90);
    apb(1'b1, 12'h00C, 8'h08);
    apb(1'b1, 12'h014, 8'h01);
    repeat (3) @(posedge pclk);
    check("ctp pa3", {pa_oe[3], pa_out[3]}, {1'b1, periph_out.ctp_out});
    check("sdo pa7", {pa_oe[7], pa_out[7]}, {1'b1, periph_out.sdo_out});
    check("tx pa6", {pa_oe[6], pa_out[6]}, {1'b1, periph_out.tx_out});
    check("scs pb5", {pb_oe[5], pb_out[5]}, {periph_out.scs_oe, periph_out.scs_out});
    // peripherals off before the selections are released
    pat <= '0;
    apb(1'b1, 12'h004, 8'h00);
    apb(1'b1, 12'h000, 8'h00);
    apb(1'b1, 12'h01C, 8'h00);
    repeat (3) @(posedge pclk);
    check("port a out", {pa_oe, pa_out}, 33'hFFFF);
    $display("test outputs done");
    close_out();
  end
endmodule

`default_nettype wire
